/* timer8_compare_waveform_gen.sv */
// 8-bit timer counter with two compare units and waveform outputs.
// Assumes a tick enable from external clock-select logic, a Wishbone master,
// and port logic that mixes waveform and port data and owns pin direction.
`timescale 1ns/1ps
`default_nettype none
`include "timer8_params.svh"

// What this block does
// - Count write blocks matches for one tick
// - Reset clears both waveform outputs
// - Mode change keeps waveform output levels
// - New action selects pin now, acts later
// - Nonzero action selection overrides port output
// - Pin override ignores waveform mode
// - Action zero leaves output unchanged
// - Force strobe applies action in non-PWM
// - Count sequence depends on mode, and on compare A in modes 2 and 7
// - Mode 0 increments and wraps FF to 00
// - Mode 0 overflow set when count zeroes
// - Mode 2 clears on compare A match
// - Mode 2 compare A unbuffered, may wrap
// - Mode 2 sets match A each period
// - Mode 2 toggle option toggles output A
// - Mode 2 overflow set on MAX to 00
// - Modes 3 and 7 fast PWM, top FF/A
// - Fast PWM clear/set on match, opposite at bottom
// - Fast PWM overflow set at top
// - Fast PWM toggle A only with high bit
// - Fast PWM extremes give spike or constant
// - Fast PWM compare values double buffered
// - PWM buffers update at top, others direct
// - Match flag set next tick, write-one clears
// - Force sets no flag, keeps counter
// - Count write beats count or clear
module timer8_compare_waveform_gen (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Timer tick enable from clock select
	input wire logic timer_tick_i,
	// Classic Wishbone slave
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// Pin source control
	output timer8_pkg::pin_ctl_type pin_ctl_o,
	// Flags as levels for an interrupt controller
	output logic overflow_flag_o,
	output logic match_a_flag_o,
	output logic match_b_flag_o
);
	import timer8_pkg::*;

	logic [7:0] ctrl_r;
	logic [7:0] count_value_r;
	logic [7:0] compare_value_a_r;
	logic [7:0] compare_value_b_r;
	logic [7:0] cmp_buf_a_r;
	logic [7:0] cmp_buf_b_r;
	logic overflow_flag_r;
	logic match_a_flag_r;
	logic match_b_flag_r;
	logic waveform_output_a_r;
	logic waveform_output_b_r;
	logic block_r;
	logic pend_a_r;
	logic pend_b_r;

	mode_type waveform_mode_sel;
	action_type output_action_sel_a;
	action_type output_action_sel_b;
	logic is_fast;
	logic nonpwm;
	logic [7:0] top;
	logic at_top;
	logic match_a;
	logic match_b;
	logic wr;
	logic rd_ack;
	logic wr_count;
	logic wr_flags;
	logic wr_force;
	logic [7:0] wbyte;

	assign waveform_mode_sel = mode_type'(ctrl_r[`CTRL_MODE_LSB +: 3]);
	assign output_action_sel_a = action_type'(ctrl_r[`CTRL_SEL_A_LSB +: 2]);
	assign output_action_sel_b = action_type'(ctrl_r[`CTRL_SEL_B_LSB +: 2]);
	assign is_fast = (waveform_mode_sel == MODE_FAST) || (waveform_mode_sel == MODE_FAST_A);
	assign nonpwm = (waveform_mode_sel == MODE_NORMAL) || (waveform_mode_sel == MODE_CTC);
	// Top uses the active compare value; mode 2 therefore sees writes at once
	assign top = (waveform_mode_sel == MODE_CTC || waveform_mode_sel == MODE_FAST_A) ?
		compare_value_a_r : `BYTE_MAX;
	assign at_top = (count_value_r == top);
	assign match_a = (count_value_r == compare_value_a_r) && !block_r;
	assign match_b = (count_value_r == compare_value_b_r) && !block_r;

	// Bus decode: single-cycle answer, ack drops the cycle after
	assign wr = cyc_i && stb_i && we_i && !ack_o;
	assign rd_ack = cyc_i && stb_i && !ack_o;
	assign wbyte = sel_i[0] ? dat_i[7:0] : 8'h00;
	assign wr_count = wr && sel_i[0] && (adr_i == `OFS_COUNT);
	assign wr_flags = wr && sel_i[0] && (adr_i == `OFS_FLAGS);
	assign wr_force = wr && sel_i[0] && (adr_i == `OFS_FORCE);

	function automatic logic apply_action(input action_type act, input logic cur);
		unique case (act)
			ACT_NONE: apply_action = cur;
			ACT_TOGGLE: apply_action = ~cur;
			ACT_CLEAR: apply_action = 1'b0;
			ACT_SET: apply_action = 1'b1;
		endcase
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= rd_ack;
			dat_o <= 32'h0000_0000;
			if (rd_ack && !we_i) begin
				unique case (adr_i)
					`OFS_CTRL: dat_o <= {24'h00_0000, ctrl_r};
					`OFS_COUNT: dat_o <= {24'h00_0000, count_value_r};
					`OFS_CMP_A: dat_o <= {24'h00_0000, is_fast ? cmp_buf_a_r : compare_value_a_r};
					`OFS_CMP_B: dat_o <= {24'h00_0000, is_fast ? cmp_buf_b_r : compare_value_b_r};
					`OFS_FLAGS: dat_o <= {29'h0000_0000, match_b_flag_r, match_a_flag_r,
						overflow_flag_r};
					default: dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Control register; mode change does not touch waveform registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r <= `CTRL_RESET;
		end else if (wr && sel_i[0] && adr_i == `OFS_CTRL) begin
			ctrl_r <= wbyte;
		end
	end

	// Counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_value_r <= `BYTE_BOTTOM;
		end else if (wr_count) begin
			count_value_r <= wbyte;
		end else if (timer_tick_i) begin
			if ((waveform_mode_sel == MODE_CTC || is_fast) && at_top) begin
				count_value_r <= `BYTE_BOTTOM;
			end else begin
				// Past an unbuffered top the count runs on and wraps
				count_value_r <= count_value_r + 8'h01;
			end
		end
	end

	// Block window: one tick after a count write, held while stopped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			block_r <= 1'b0;
		end else if (wr_count) begin
			block_r <= 1'b1;
		end else if (timer_tick_i) begin
			block_r <= 1'b0;
		end
	end

	// Compare values: direct in non-PWM, buffered and loaded at top in PWM
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			compare_value_a_r <= `BYTE_BOTTOM;
			compare_value_b_r <= `BYTE_BOTTOM;
			cmp_buf_a_r <= `BYTE_BOTTOM;
			cmp_buf_b_r <= `BYTE_BOTTOM;
		end else begin
			if (wr && sel_i[0] && adr_i == `OFS_CMP_A) begin
				cmp_buf_a_r <= wbyte;
			end
			if (wr && sel_i[0] && adr_i == `OFS_CMP_B) begin
				cmp_buf_b_r <= wbyte;
			end
			if (nonpwm) begin
				if (wr && sel_i[0] && adr_i == `OFS_CMP_A) begin
					compare_value_a_r <= wbyte;
				end
				if (wr && sel_i[0] && adr_i == `OFS_CMP_B) begin
					compare_value_b_r <= wbyte;
				end
			end else if (timer_tick_i && at_top) begin
				compare_value_a_r <= cmp_buf_a_r;
				compare_value_b_r <= cmp_buf_b_r;
			end
		end
	end

	// Matches are seen one tick later, then flags set; set wins over clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_a_r <= 1'b0;
			pend_b_r <= 1'b0;
		end else if (timer_tick_i) begin
			pend_a_r <= match_a;
			pend_b_r <= match_b;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_flag_r <= 1'b0;
			match_a_flag_r <= 1'b0;
			match_b_flag_r <= 1'b0;
		end else begin
			if (timer_tick_i && !wr_count &&
				((is_fast && at_top) || (!is_fast && count_value_r == `BYTE_MAX))) begin
				overflow_flag_r <= 1'b1;
			end else if (wr_flags && wbyte[`FLAG_OVF]) begin
				overflow_flag_r <= 1'b0;
			end
			if (timer_tick_i && pend_a_r) begin
				match_a_flag_r <= 1'b1;
			end else if (wr_flags && wbyte[`FLAG_MA]) begin
				match_a_flag_r <= 1'b0;
			end
			if (timer_tick_i && pend_b_r) begin
				match_b_flag_r <= 1'b1;
			end else if (wr_flags && wbyte[`FLAG_MB]) begin
				match_b_flag_r <= 1'b0;
			end
		end
	end

	// Waveform output registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			waveform_output_a_r <= `WAVE_RESET;
			waveform_output_b_r <= `WAVE_RESET;
		end else if (nonpwm) begin
			if (wr_force && wbyte[`FORCE_A]) begin
				waveform_output_a_r <= apply_action(output_action_sel_a, waveform_output_a_r);
			end else if (timer_tick_i && match_a) begin
				waveform_output_a_r <= apply_action(output_action_sel_a, waveform_output_a_r);
			end
			if (wr_force && wbyte[`FORCE_B]) begin
				waveform_output_b_r <= apply_action(output_action_sel_b, waveform_output_b_r);
			end else if (timer_tick_i && match_b) begin
				waveform_output_b_r <= apply_action(output_action_sel_b, waveform_output_b_r);
			end
		end else if (is_fast && timer_tick_i) begin
			// Match at top is ignored for PWM polarity; bottom action wins
			if (output_action_sel_a == ACT_TOGGLE) begin
				if (match_a && ctrl_r[`CTRL_MODE_LSB + 2]) begin
					waveform_output_a_r <= ~waveform_output_a_r;
				end
			end else if (output_action_sel_a != ACT_NONE) begin
				if (at_top) begin
					waveform_output_a_r <= (output_action_sel_a == ACT_CLEAR);
				end else if (match_a) begin
					waveform_output_a_r <= (output_action_sel_a == ACT_SET);
				end
			end
			if (output_action_sel_b[1]) begin
				if (at_top) begin
					waveform_output_b_r <= (output_action_sel_b == ACT_CLEAR);
				end else if (match_b) begin
					waveform_output_b_r <= (output_action_sel_b == ACT_SET);
				end
			end
		end
	end

	// Pin source follows the selection at once, whatever the mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_ctl_o <= '0;
			overflow_flag_o <= 1'b0;
			match_a_flag_o <= 1'b0;
			match_b_flag_o <= 1'b0;
		end else begin
			pin_ctl_o.wave_a <= waveform_output_a_r;
			pin_ctl_o.wave_b <= waveform_output_b_r;
			pin_ctl_o.own_a <= (output_action_sel_a != ACT_NONE);
			pin_ctl_o.own_b <= (output_action_sel_b != ACT_NONE);
			overflow_flag_o <= overflow_flag_r;
			match_a_flag_o <= match_a_flag_r;
			match_b_flag_o <= match_b_flag_r;
		end
	end
endmodule
`default_nettype wire

/* timer8_params.svh */
// Constants for the 8-bit compare/waveform timer: offsets, fields, reset values.
// Assumes a classic Wishbone slave with 32-bit data, one register per word.
`ifndef TIMER8_PARAMS_SVH
`define TIMER8_PARAMS_SVH

`define OFS_CTRL 8'h00
`define OFS_COUNT 8'h04
`define OFS_CMP_A 8'h08
`define OFS_CMP_B 8'h0C
`define OFS_FLAGS 8'h10
`define OFS_FORCE 8'h14

`define CTRL_MODE_LSB 0
`define CTRL_SEL_B_LSB 4
`define CTRL_SEL_A_LSB 6
`define FLAG_OVF 0
`define FLAG_MA 1
`define FLAG_MB 2
`define FORCE_A 0
`define FORCE_B 1

`define CTRL_RESET 8'h00
`define BYTE_MAX 8'hFF
`define BYTE_BOTTOM 8'h00
`define WAVE_RESET 1'b0

`endif

/* timer8_pkg.sv */
// Types for the 8-bit compare/waveform timer.
// Assumes nothing beyond the constants header.
package timer8_pkg;
	typedef enum logic [2:0] {
		MODE_NORMAL = 3'h0,
		MODE_PCPWM = 3'h1,
		MODE_CTC = 3'h2,
		MODE_FAST = 3'h3,
		MODE_RSVD4 = 3'h4,
		MODE_PCPWM_A = 3'h5,
		MODE_RSVD6 = 3'h6,
		MODE_FAST_A = 3'h7
	} mode_type;

	typedef enum logic [1:0] {
		ACT_NONE = 2'h0,
		ACT_TOGGLE = 2'h1,
		ACT_CLEAR = 2'h2,
		ACT_SET = 2'h3
	} action_type;

	typedef struct packed {
		logic wave_a;
		logic wave_b;
		logic own_a;
		logic own_b;
	} pin_ctl_type;
endpackage

/* timer8_asserts.sv */
// Port checker for the 8-bit compare/waveform timer.
// Assumes it is bound onto the timer top module.
`timescale 1ns/1ps
`default_nettype none
module timer8_asserts (
	// Clock, reset, tick
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic timer_tick_i,
	// Bus
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	// Pins and flags
	input wire timer8_pkg::pin_ctl_type pin_ctl_o,
	input wire logic overflow_flag_o,
	input wire logic match_a_flag_o,
	input wire logic match_b_flag_o
);
	import timer8_pkg::*;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire wr = cyc_i && stb_i && we_i && sel_i[0];
	wire fl = wr && adr_i == 8'h10;
	logic [2:0] tk_h, ev_h, cw_h, c0_h, c1_h;
	// Three-deep history stands in for the one-clock output lag plus bus take
	always_ff @(posedge clk_i) begin
		tk_h <= {tk_h[1:0], timer_tick_i};
		ev_h <= {ev_h[1:0], timer_tick_i || (wr && adr_i == 8'h14)};
		cw_h <= {cw_h[1:0], wr && adr_i == 8'h00};
		c0_h <= {c0_h[1:0], fl && dat_i[0]};
		c1_h <= {c1_h[1:0], fl && dat_i[1]};
	end
	a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
	a_ack_follows: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("no ack");
	a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data not idle");
	a_reset_wave: assert property (disable iff (1'b0) rst_i [*3] |-> pin_ctl_o == 4'h0)
		else $error("outputs not cleared by reset");
	a_own_cause: assert property ($changed(pin_ctl_o.own_a) |-> |cw_h)
		else $error("pin source changed without control write");
	a_wave_cause: assert property ($changed(pin_ctl_o.wave_a) |-> |ev_h)
		else $error("wave changed without tick or force");
	a_ovf_tick: assert property ($rose(overflow_flag_o) |-> |tk_h)
		else $error("overflow set without tick");
	a_ovf_keep: assert property ($fell(overflow_flag_o) |-> |c0_h)
		else $error("overflow cleared by hardware");
	a_ma_tick: assert property ($rose(match_a_flag_o) |-> |tk_h)
		else $error("match flag set without tick");
	a_ma_keep: assert property ($fell(match_a_flag_o) |-> |c1_h)
		else $error("match flag cleared by hardware");
endmodule
bind timer8_compare_waveform_gen timer8_asserts chk (.clk_i(clk_i), .rst_i(rst_i),
	.timer_tick_i(timer_tick_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .pin_ctl_o(pin_ctl_o),
	.overflow_flag_o(overflow_flag_o), .match_a_flag_o(match_a_flag_o),
	.match_b_flag_o(match_b_flag_o));
`default_nettype wire

/* port_pin_model.sv */
// Port pin mux with pull-ups, standing for the loads on the two pins.
// Assumes bit 1 is pin A and bit 0 is pin B.
`timescale 1ns/1ps
`default_nettype none
module port_pin_model (
	// Timer side
	input wire timer8_pkg::pin_ctl_type pin_ctl_i,
	// Port side
	input wire logic [1:0] port_out_i,
	input wire logic [1:0] dir_out_i,
	output logic [1:0] pin_o
);
	import timer8_pkg::*;
	// Undriven pins float up, so direction must be output to see the wave
	assign pin_o[1] = dir_out_i[1] ? (pin_ctl_i.own_a ? pin_ctl_i.wave_a : port_out_i[1]) : 1'b1;
	assign pin_o[0] = dir_out_i[0] ? (pin_ctl_i.own_b ? pin_ctl_i.wave_b : port_out_i[0]) : 1'b1;
endmodule
`default_nettype wire

/* tb_top.sv */
// Bench for the 8-bit compare/waveform timer: bus tasks and timer scenarios.
// Assumes the pin model beside it and the ticks driven here.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import timer8_pkg::*;
	logic clk_i = 0, rst_i = 1, tick = 0, cyc = 0, stb = 0, we = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0, rd;
	logic [31:0] dat;
	logic ack, ovf, ma, mb;
	pin_ctl_type pc;
	logic [1:0] pin;
	int err_count = 0, checks_done = 0, cycles = 0;
	timer8_compare_waveform_gen DUT (.clk_i(clk_i), .rst_i(rst_i), .timer_tick_i(tick),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat),
		.dat_o(dat), .ack_o(ack), .pin_ctl_o(pc), .overflow_flag_o(ovf),
		.match_a_flag_o(ma), .match_b_flag_o(mb));
	port_pin_model pins (.pin_ctl_i(pc), .port_out_i(2'h0), .dir_out_i(2'h2), .pin_o(pin));
	initial forever #2.5 clk_i = ~clk_i;
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1;
		stb <= 1;
		we <= w;
		adr <= a;
		wdat <= d;
		do @(posedge clk_i); while (ack !== 1'b1);
		rd = dat;
		cyc <= 0;
		stb <= 0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		wb(0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic tk(input int n);
		@(posedge clk_i);
		tick <= 1;
		repeat (n) @(posedge clk_i);
		tick <= 0;
	endtask
	// Flags and pins lag the state by a clock
	task automatic st;
		repeat (3) @(posedge clk_i);
		#1;
	endtask
	task automatic test_done;
		$display("errors=%0d checks=%0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			err_count++;
			test_done;
		end
	end
	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		#1;
		chk({28'h0, pc}, 32'h0);
		rdc(8'h00, 32'h0);
		wb(1, 8'h08, 32'h07);
		wb(1, 8'h04, 32'hFE);
		tk(1);
		rdc(8'h04, 32'hFF);
		st;
		chb(ovf, 0);
		tk(1);
		rdc(8'h04, 32'h00);
		st;
		chb(ovf, 1);
		wb(1, 8'h00, 32'h40);
		wb(1, 8'h10, 32'h07);
		wb(1, 8'h04, 32'h07);
		tk(1);
		st;
		chb(ma, 0);
		chb(pc.wave_a, 0);
		chb(pc.own_a, 1);
		tk(255);
		tk(2);
		st;
		chb(ma, 1);
		chb(pc.wave_a, 1);
		rdc(8'h04, 32'h09);
		wb(1, 8'h10, 32'h07);
		wb(1, 8'h00, 32'h80);
		wb(1, 8'h14, 32'h01);
		st;
		chb(pc.wave_a, 0);
		chb(ma, 0);
		rdc(8'h04, 32'h09);
		wb(1, 8'h00, 32'hC0);
		wb(1, 8'h14, 32'h01);
		wb(1, 8'h00, 32'hC3);
		st;
		chb(pc.wave_a, 1);
		chb(pin[1], 1);
		wb(1, 8'h00, 32'h02);
		st;
		chb(pc.own_a, 0);
		chb(pin[1], 0);
		wb(1, 8'h00, 32'h42);
		wb(1, 8'h08, 32'h03);
		wb(1, 8'h04, 32'h00);
		tk(4);
		rdc(8'h04, 32'h00);
		tk(1);
		st;
		chb(ma, 1);
		chb(pc.wave_a, 0);
		chb(ovf, 0);
		wb(1, 8'h10, 32'h07);
		wb(1, 8'h04, 32'h10);
		tk(240);
		rdc(8'h04, 32'h00);
		st;
		chb(ovf, 1);
		chb(ma, 0);
		wb(1, 8'h10, 32'h07);
		wb(1, 8'h00, 32'h83);
		wb(1, 8'h04, 32'hFE);
		tk(2);
		rdc(8'h04, 32'h00);
		st;
		chb(ovf, 1);
		chb(pc.wave_a, 1);
		wb(1, 8'h08, 32'h01);
		tk(2);
		st;
		chb(pc.wave_a, 1);
		tk(3);
		st;
		chb(pc.wave_a, 0);
		wb(1, 8'h10, 32'h07);
		wb(1, 8'h00, 32'h10);
		wb(1, 8'h08, 32'h05);
		wb(1, 8'h0C, 32'h05);
		wb(1, 8'h04, 32'h04);
		tk(2);
		tk(1);
		st;
		chb(mb, 1);
		chb(pc.wave_b, 1);
		chb(pc.own_b, 1);
		chb(pin[0], 1);
		chb(pc.wave_a, 0);
		chb(pc.own_a, 0);
		test_done;
	end
endmodule
`default_nettype wire
